// ### adc_conversion_sequencer.sv
// conversion sequencer for the delta-sigma and successive approximation converters
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "adc_seq_defines.svh"
module adc_conversion_sequencer
   import adc_seq_pkg::*;
(
   input  wire logic        core_clk,      // system clock, 125 MHz
   input  wire logic        resetn,        // asynchronous reset, active low
   input  wire logic [7:0]  s_axi_awaddr,  // write address
   input  wire logic        s_axi_awvalid, // write address valid
   output logic             s_axi_awready, // write address ready
   input  wire logic [31:0] s_axi_wdata,   // write data
   input  wire logic [3:0]  s_axi_wstrb,   // write byte enables
   input  wire logic        s_axi_wvalid,  // write data valid
   output logic             s_axi_wready,  // write data ready
   output logic [1:0]       s_axi_bresp,   // write response
   output logic             s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_bready,  // write response ready
   input  wire logic [7:0]  s_axi_araddr,  // read address
   input  wire logic        s_axi_arvalid, // read address valid
   output logic             s_axi_arready, // read address ready
   output logic [31:0]      s_axi_rdata,   // read data
   output logic [1:0]       s_axi_rresp,   // read response
   output logic             s_axi_rvalid,  // read data valid
   input  wire logic        s_axi_rready,  // read data ready
   input  wire logic        ds_soc,        // delta-sigma start trigger
   input  wire logic        ds_conv_end,   // decimator: one conversion period finished
   input  wire logic [19:0] ds_data,       // decimator output word
   output logic             ds_mod_reset,  // reset pulse to modulator and decimator
   output logic             ds_eoc,        // delta-sigma end of conversion
   input  wire logic        sar_sof,       // successive approx frame trigger
   input  wire logic        sar_cmp,       // comparator: input above dac level
   output logic             sar_clk_tick,  // conversion clock strobe
   output logic [11:0]      sar_dac,       // trial code to the internal dac
   output logic             sar_eof,       // successive approx frame done
   output logic             irq            // level interrupt
);
   ctrl_t            ctrl, next_ctrl;
   logic [7:0]       sar_div, next_sar_div;
   logic [1:0]       irq_stat, next_irq_stat, irq_mask, next_irq_mask;
   logic             aw_full, next_aw_full, w_full, next_w_full;
   logic [7:0]       aw_addr, next_aw_addr;
   logic [31:0]      w_data, next_w_data, rd_word;
   logic             next_bvalid, next_rvalid;
   logic [1:0]       next_bresp, next_rresp;
   logic [31:0]      next_rdata;
   logic             wr_do, rd_take, rd_ds, rd_sar, ds_start_wr, sar_start_wr;
   ds_state_t        ds_state, next_ds_state;
   logic [1:0]       ds_cnt, next_ds_cnt;
   logic             ds_done, next_ds_done, next_ds_mod_reset, ds_done_set;
   logic [19:0]      ds_result, next_ds_result;
   sar_state_t       sar_state, next_sar_state;
   logic [10:0]      wake_cnt, next_wake_cnt;
   logic [7:0]       div_cnt, next_div_cnt, div_eff;
   logic [4:0]       sar_step, next_sar_step;
   logic [11:0]      next_sar_dac, sar_result, next_sar_result, trial;
   logic             sar_done, next_sar_done, sar_done_set, next_tick;

   // register bus handshakes: one write and one read in flight at a time
   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready  = !w_full && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_do         = aw_full && w_full && !s_axi_bvalid;
   assign rd_take       = s_axi_arvalid && s_axi_arready;
   // reading a result clears its status
   assign rd_ds         = rd_take && (s_axi_araddr == `OFF_DS_RESULT);
   assign rd_sar        = rd_take && (s_axi_araddr == `OFF_SAR_RESULT);
   assign ds_start_wr   = wr_do && (aw_addr == `OFF_CTRL) && w_data[`CTRL_DS_START];
   // software start bit; lanes without a strobe were zeroed when taken
   assign sar_start_wr  = wr_do && (aw_addr == `OFF_CTRL) && w_data[`CTRL_SAR_START];
   assign irq   = |(irq_stat & irq_mask);

   // read data selection; reserved bits read as zero
   always_comb begin
      rd_word = 32'h0;
      unique case (s_axi_araddr)
         `OFF_CTRL:       rd_word = {20'h0, ctrl.sar_power, ctrl.single_conversion_select,
                                     1'b0, ctrl.ds_res, ctrl.ds_enable, ctrl.ds_mode, 1'b0};
         `OFF_STATUS:     rd_word = {29'h0, sar_state == SAR_READY, sar_done, ds_done};
         `OFF_DS_RESULT:  rd_word = {12'h0, ds_result};
         `OFF_SAR_RESULT: rd_word = {20'h0, sar_result};
         `OFF_IRQ_STAT:   rd_word = {30'h0, irq_stat};
         `OFF_IRQ_MASK:   rd_word = {30'h0, irq_mask};
         `OFF_SAR_DIV:    rd_word = {24'h0, sar_div};
         default:         rd_word = 32'h0;
      endcase
   end

   // bus and register next state; a hardware set wins over a read clear
   always_comb begin
      next_aw_full  = aw_full;
      next_aw_addr  = aw_addr;
      next_w_full   = w_full;
      next_w_data   = w_data;
      next_bvalid   = s_axi_bvalid && !s_axi_bready;
      next_bresp    = s_axi_bresp;
      next_rvalid   = s_axi_rvalid && !s_axi_rready;
      next_rresp    = s_axi_rresp;
      next_rdata    = s_axi_rdata;
      next_ctrl     = ctrl;
      next_sar_div  = sar_div;
      next_irq_mask = irq_mask;
      next_irq_stat = irq_stat;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_full = 1'b1;
         next_aw_addr = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_full = 1'b1;
         next_w_data = s_axi_wdata & wmask_of(s_axi_wstrb);
      end
      if (wr_do) begin
         next_aw_full = 1'b0;
         next_w_full  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = 2'b00;
         unique case (aw_addr)
            `OFF_CTRL: begin
               next_ctrl.ds_mode   = ds_mode_t'(w_data[`CTRL_DS_MODE +: 2]);
               next_ctrl.ds_enable = w_data[`CTRL_DS_EN];
               next_ctrl.ds_res    = w_data[`CTRL_DS_RES +: 5];
               next_ctrl.single_conversion_select = w_data[`CTRL_SAR_SCS];
               next_ctrl.sar_power = w_data[`CTRL_SAR_PWR];
            end
            `OFF_IRQ_MASK: next_irq_mask = w_data[1:0];
            `OFF_SAR_DIV:  next_sar_div = w_data[7:0];
            `OFF_STATUS, `OFF_DS_RESULT, `OFF_SAR_RESULT, `OFF_IRQ_STAT: ;
            default:       next_bresp = 2'b11;
         endcase
      end
      if (rd_take) begin
         next_rvalid = 1'b1;
         next_rdata  = rd_word;
         next_rresp  = (s_axi_araddr > `OFF_SAR_DIV) ? 2'b11 : 2'b00;
         if (s_axi_araddr == `OFF_IRQ_STAT)
            next_irq_stat = 2'b00;
      end
      next_irq_stat = next_irq_stat | {sar_done_set, ds_done_set};
   end
   function automatic logic [31:0] wmask_of(input logic [3:0] strb);
      wmask_of = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction : wmask_of
   // delta-sigma sequencing: prime count, resets and completion
   always_comb begin
      next_ds_state     = ds_state;
      next_ds_cnt       = ds_cnt;
      next_ds_mod_reset = 1'b0;
      next_ds_result    = ds_result;
      ds_done_set       = 1'b0;
      unique case (ds_state)
         DS_IDLE: begin
            // trigger or start bit begins a conversion
            if (ctrl.ds_enable && (ds_soc || ds_start_wr)) begin
               next_ds_state     = DS_CONV;
               next_ds_cnt       = `DS_PRIME_CNT;
               next_ds_mod_reset = 1'b1;
            end
         end
         DS_CONV: begin
            if (!ctrl.ds_enable) begin
               // a reset pulse also lands when the run ends
               next_ds_state     = DS_IDLE;
               next_ds_mod_reset = 1'b1;
            end else if (ds_conv_end && !ds_mod_reset && ds_cnt != 2'h0) begin
               next_ds_cnt = ds_cnt - 2'h1; // a pulse under the reset ends the old period
            end else if (ds_conv_end && !ds_mod_reset) begin
               ds_done_set    = 1'b1;
               next_ds_result = ds_data;
               unique case (ctrl.ds_mode)
                  DS_SINGLE: next_ds_state = DS_IDLE;
                  // continuous runs on without the trigger
                  DS_CONT:   next_ds_cnt = 2'h0;
                  // low turbo resolutions re-prime like multi-sample
                  DS_MULTI, DS_TURBO: begin
                     if (ctrl.ds_mode == DS_TURBO && ctrl.ds_res > `DS_TURBO_RES) begin
                        next_ds_cnt = 2'h0;
                     end else begin
                        next_ds_cnt       = `DS_PRIME_CNT;
                        next_ds_mod_reset = 1'b1;
                     end
                  end
               endcase
            end
         end
      endcase
      // completion held until the result is read
      next_ds_done = ds_done_set || (ds_done && !rd_ds);
   end
   // conversion clock kept between 1 and 18 MHz
   assign div_eff = (sar_div < 8'(`SAR_DIV_MIN)) ? 8'(`SAR_DIV_MIN) :
                    (sar_div > 8'(`SAR_DIV_MAX)) ? 8'(`SAR_DIV_MAX) : sar_div;
   // decision on the bit now under trial
   assign trial = sar_cmp ? sar_dac
                          : (sar_dac & ~(12'h800 >> 4'(sar_step - 5'h1)));

   // successive approx power, wake wait and binary search
   always_comb begin
      next_sar_state  = sar_state;
      next_wake_cnt   = wake_cnt;
      next_div_cnt    = div_cnt;
      next_sar_step   = sar_step;
      next_sar_dac    = sar_dac;
      next_sar_result = sar_result;
      next_tick       = 1'b0;
      sar_done_set    = 1'b0;
      unique case (sar_state)
         SAR_OFF: begin
            next_wake_cnt = 11'h0;
            if (ctrl.sar_power)
               next_sar_state = SAR_WAKE;
         end
         // no start until the wake wait has run out
         SAR_WAKE: begin
            next_wake_cnt = wake_cnt + 11'h1;
            if (wake_cnt == 11'(`SAR_WAIT_CYC - 1))
               next_sar_state = SAR_READY;
         end
         SAR_READY: begin
            // one conversion per trigger or a continuous run
            if (sar_sof || sar_start_wr) begin
               next_sar_state = SAR_CONV;
               next_div_cnt   = 8'h0;
               next_sar_step  = 5'h0;
            end
         end
         SAR_CONV: begin
            next_div_cnt = div_cnt + 8'h1;
            if (div_cnt == div_eff - 8'h1) begin
               next_div_cnt = 8'h0;
               next_tick    = 1'b1;
               next_sar_step = sar_step + 5'h1;
               if (sar_step == 5'h0) begin
                  next_sar_dac = 12'h800;
               end else if (sar_step <= `SAR_RES_STEP) begin
                  next_sar_dac = trial | (12'h800 >> 4'(sar_step));
                  if (sar_step == `SAR_RES_STEP) begin
                     next_sar_dac    = trial;
                     next_sar_result = trial;
                  end
               end
               // eighteen conversion clocks make one sample
               if (sar_step == `SAR_STEPS - 5'h1) begin
                  sar_done_set  = 1'b1;
                  next_sar_step = 5'h0;
                  // continuous results stream out, frame-done sets the sar status and event
                  if (ctrl.single_conversion_select)
                     next_sar_state = SAR_READY;
               end
            end
         end
      endcase
      if (!ctrl.sar_power)
         next_sar_state = SAR_OFF;
      // frame-done held until the result is read
      next_sar_done = sar_done_set || (sar_done && !rd_sar);
   end
   // all state registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         aw_full <= 1'b0;  aw_addr <= 8'h0;  w_full <= 1'b0;  w_data <= 32'h0;
         s_axi_bvalid <= 1'b0;  s_axi_bresp <= 2'b00;
         s_axi_rvalid <= 1'b0;  s_axi_rresp <= 2'b00;  s_axi_rdata <= 32'h0;
         ctrl <= '{sar_power: 1'b0, single_conversion_select: 1'b0,
                   ds_res: `DS_RES_RST, ds_enable: 1'b0, ds_mode: DS_SINGLE};
         sar_div <= 8'(`SAR_DIV_MIN);  irq_stat <= 2'b00;  irq_mask <= 2'b00;
         ds_state <= DS_IDLE;  ds_cnt <= 2'h0;  ds_done <= 1'b0;
         ds_mod_reset <= 1'b0;  ds_result <= 20'h0;
         sar_state <= SAR_OFF;  wake_cnt <= 11'h0;  div_cnt <= 8'h0;
         sar_step <= 5'h0;  sar_dac <= 12'h0;  sar_result <= 12'h0;
         sar_done <= 1'b0;  sar_clk_tick <= 1'b0;
      end else begin
         aw_full <= next_aw_full;  aw_addr <= next_aw_addr;
         w_full <= next_w_full;  w_data <= next_w_data;
         s_axi_bvalid <= next_bvalid;  s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;  s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
         ctrl <= next_ctrl;  sar_div <= next_sar_div;
         irq_stat <= next_irq_stat;  irq_mask <= next_irq_mask;
         ds_state <= next_ds_state;  ds_cnt <= next_ds_cnt;  ds_done <= next_ds_done;
         ds_mod_reset <= next_ds_mod_reset;  ds_result <= next_ds_result;
         sar_state <= next_sar_state;  wake_cnt <= next_wake_cnt;
         div_cnt <= next_div_cnt;  sar_step <= next_sar_step;  sar_dac <= next_sar_dac;
         sar_result <= next_sar_result;  sar_done <= next_sar_done;
         sar_clk_tick <= next_tick;
      end
   end
   assign ds_eoc  = ds_done;
   assign sar_eof = sar_done;
   a_ds_trig_start: assert property (@(posedge core_clk) disable iff (!resetn)
      ds_state == DS_IDLE && ctrl.ds_enable && ds_soc |=> ds_state == DS_CONV && ds_mod_reset)
      else $error("trigger did not start a conversion");
   a_ds_single_four: assert property (@(posedge core_clk) disable iff (!resetn)
      ds_state == DS_CONV && ctrl.ds_enable && ctrl.ds_mode == DS_SINGLE && ds_conv_end
      && ds_cnt == 2'h0 |=> ds_state == DS_IDLE && ds_eoc)
      else $error("single sample did not finish after its fourth conversion");
   a_ds_turbo_hold: assert property (@(posedge core_clk) disable iff (!resetn)
      ds_state == DS_CONV && ctrl.ds_enable && ctrl.ds_mode == DS_TURBO
      && ctrl.ds_res > `DS_TURBO_RES && ds_conv_end |=> !ds_mod_reset)
      else $error("high resolution turbo reset between samples");
   a_ds_multi_reprime: assert property (@(posedge core_clk) disable iff (!resetn)
      ds_state == DS_CONV && ctrl.ds_enable && ctrl.ds_mode == DS_MULTI && ds_conv_end
      && ds_cnt == 2'h0 |=> ds_mod_reset && ds_cnt == 2'h3 && ds_state == DS_CONV)
      else $error("multi sample did not re-prime");
   a_ds_eoc_held: assert property (@(posedge core_clk) disable iff (!resetn)
      ds_eoc && !rd_ds |=> ds_eoc)
      else $error("completion dropped before result read");
   a_sar_wake_wait: assert property (@(posedge core_clk) disable iff (!resetn)
      sar_state == SAR_WAKE && wake_cnt != 11'(`SAR_WAIT_CYC - 1) |=> sar_state != SAR_READY)
      else $error("ready before the wake wait ran out");
   a_sar_msb_first: assert property (@(posedge core_clk) disable iff (!resetn)
      sar_state == SAR_CONV && sar_step == 5'h0 && next_tick |=> sar_dac == 12'h800)
      else $error("search did not begin at the top bit");
   a_sar_eof_held: assert property (@(posedge core_clk) disable iff (!resetn)
      sar_eof && !rd_sar |=> sar_eof)
      else $error("frame done dropped before result read");
   a_sar_single_stop: assert property (@(posedge core_clk) disable iff (!resetn)
      sar_done_set && ctrl.sar_power && ctrl.single_conversion_select
      |=> sar_state == SAR_READY ##1 sar_eof || $past(rd_sar))
      else $error("single conversion did not stop");
endmodule : adc_conversion_sequencer

// ### adc_seq_defines.svh
// register offsets, field positions, reset values and timing counts of the conversion sequencer
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

`define OFF_CTRL       8'h00
`define OFF_STATUS     8'h04
`define OFF_DS_RESULT  8'h08
`define OFF_SAR_RESULT 8'h0c
`define OFF_IRQ_STAT   8'h10
`define OFF_IRQ_MASK   8'h14
`define OFF_SAR_DIV    8'h18

`define CTRL_DS_START  0
`define CTRL_DS_MODE   1
`define CTRL_DS_EN     3
`define CTRL_DS_RES    4
`define CTRL_SAR_START 9
`define CTRL_SAR_SCS   10
`define CTRL_SAR_PWR   11

`define DS_RES_RST     5'h10
`define DS_TURBO_RES   5'h10
`define DS_PRIME_CNT   2'h3

`define SAR_BITS       12
`define SAR_STEPS      5'h12
`define SAR_RES_STEP   5'h0c

`define CLK_MHZ        125
`define SAR_WAIT_NS    10000
`define SAR_WAIT_CYC   ((`SAR_WAIT_NS * `CLK_MHZ + 999) / 1000)
`define SAR_FMAX_MHZ   18
`define SAR_FMIN_MHZ   1
`define SAR_DIV_MIN    ((`CLK_MHZ + `SAR_FMAX_MHZ - 1) / `SAR_FMAX_MHZ)
`define SAR_DIV_MAX    (`CLK_MHZ / `SAR_FMIN_MHZ)

`endif

// ### adc_seq_pkg.sv
// types shared by the conversion sequencer
package adc_seq_pkg;
   typedef enum logic [1:0] {
      DS_SINGLE = 2'b00,
      DS_MULTI  = 2'b01,
      DS_CONT   = 2'b10,
      DS_TURBO  = 2'b11
   } ds_mode_t;
   typedef enum logic {DS_IDLE = 1'b0, DS_CONV = 1'b1} ds_state_t;
   typedef enum logic [1:0] {
      SAR_OFF   = 2'b00,
      SAR_WAKE  = 2'b01,
      SAR_READY = 2'b10,
      SAR_CONV  = 2'b11
   } sar_state_t;
   typedef struct packed {
      logic                    sar_power;
      logic                    single_conversion_select;
      logic [4:0]              ds_res;
      logic                    ds_enable;
      ds_mode_t                ds_mode;
   } ctrl_t;
endpackage : adc_seq_pkg

// ### adc_far_side_model.sv
// far side model: decimator pulse source and comparator of the sequencer
`timescale 1ns/10ps
module adc_far_side_model #(
   parameter int          PERIOD = 20,      // core clocks per decimator conversion
   parameter logic [11:0] LEVEL  = 12'ha5c  // analog level seen by the comparator
) (
   input  wire logic        core_clk,     // system clock
   input  wire logic        resetn,       // asynchronous reset, active low
   input  wire logic        ds_mod_reset, // modulator and decimator reset pulse
   input  wire logic [11:0] sar_dac,      // trial code from the sequencer
   output logic             ds_conv_end,  // one pulse per conversion period
   output logic [19:0]      ds_data,      // decimator word
   output logic             sar_cmp,      // comparator answer
   output int               pulses        // conversions since the last reset pulse
);
   int div;
   assign sar_cmp = (LEVEL >= sar_dac);
   assign ds_data = 20'h5a5a3;
   // reset restarts the pulse count; the period runs free, so the first pulse after a reset can come early
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         div         <= 0;
         ds_conv_end <= 1'b0;
         pulses      <= 0;
      end else begin
         div         <= (div == PERIOD - 1) ? 0 : div + 1;
         ds_conv_end <= (div == PERIOD - 1);
         if (ds_mod_reset)
            pulses <= 0;
         else if (ds_conv_end)
            pulses <= pulses + 1;
      end
   end
endmodule : adc_far_side_model

// ### tb.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/10ps
`include "adc_seq_defines.svh"
module tb;
   import adc_seq_pkg::*;
   logic        core_clk, resetn, ds_soc, sar_sof, ds_conv_end, sar_cmp, irq, ds_mod_reset;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        ds_eoc, sar_eof, sar_clk_tick;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
   logic [19:0] ds_data;
   logic [11:0] sar_dac;
   int          pulses, snap, cycles, compares, failures, ticks, t0;
   adc_conversion_sequencer dut (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ds_soc, .ds_conv_end,
      .ds_data, .ds_mod_reset, .ds_eoc, .sar_sof, .sar_cmp, .sar_clk_tick, .sar_dac,
      .sar_eof, .irq);
   adc_far_side_model far (.core_clk, .resetn, .ds_mod_reset, .sar_dac, .ds_conv_end,
      .ds_data, .sar_cmp, .pulses);
   task automatic print_verdict();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : check
   // the bus tasks open on a rising edge and sample at the falling one, clear of update races
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok, b_ok;
      int   n;
      n = 0;
      @(posedge core_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(negedge core_clk);
         aw_ok = s_axi_awready & s_axi_awvalid;
         w_ok  = s_axi_wready & s_axi_wvalid;
         b_ok  = s_axi_bvalid;
         br    = s_axi_bresp;
         @(posedge core_clk);
         if (aw_ok) s_axi_awvalid <= 1'b0;
         if (w_ok) s_axi_wvalid <= 1'b0;
         n++;
      end while (!b_ok && n < 50);
      s_axi_bready <= 1'b0;
      check({31'h0, b_ok}, 32'h1, "write answered");
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a);
      logic ar_ok, r_ok;
      int   n;
      n = 0;
      @(posedge core_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(negedge core_clk);
         ar_ok = s_axi_arready & s_axi_arvalid;
         r_ok  = s_axi_rvalid;
         rd    = s_axi_rdata;
         rr    = s_axi_rresp;
         @(posedge core_clk);
         if (ar_ok) s_axi_arvalid <= 1'b0;
         n++;
      end while (!r_ok && n < 50);
      s_axi_rready <= 1'b0;
      check({31'h0, r_ok}, 32'h1, "read answered");
   endtask : axi_read
   task automatic expect_read(input logic [7:0] a, input logic [31:0] exp, input string what);
      axi_read(a);
      check(rd, exp, what);
   endtask : expect_read
   // snap keeps the decimator count seen the moment the flag rose
   task automatic wait_high(ref logic sig, input int lim);
      logic ok;
      int   n;
      n = 0;
      do begin
         @(negedge core_clk);
         ok   = (sig === 1'b1);
         snap = pulses;
         @(posedge core_clk);
         n++;
      end while (!ok && n < lim);
      check({31'h0, ok}, 32'h1, "flag in time");
   endtask : wait_high
   // one-cycle trigger: sar selects the frame trigger, otherwise the start trigger
   task automatic pulse(input logic successive_approx_converter);
      @(posedge core_clk);
      if (successive_approx_converter)
         sar_sof <= 1'b1;
      else
         ds_soc <= 1'b1;
      @(posedge core_clk);
      {ds_soc, sar_sof} <= 2'b00;
   endtask : pulse
   task automatic sc_ds_single();
      axi_write(`OFF_IRQ_MASK, 32'h1);
      axi_write(`OFF_CTRL, 32'h108);
      pulse(1'b0);
      wait_high(ds_eoc, 300);
      check(snap, 4, "single primes three");
      repeat (40) @(posedge core_clk);
      @(negedge core_clk);
      check({30'h0, ds_eoc, irq}, 32'h3, "done held till read");
      expect_read(`OFF_DS_RESULT, 32'h5a5a3, "ds result");
      @(negedge core_clk);
      check({31'h0, ds_eoc}, 32'h0, "read clears done");
      repeat (150) @(negedge core_clk);
      check({31'h0, ds_eoc}, 32'h0, "standby after one");
      expect_read(`OFF_IRQ_STAT, 32'h1, "ds event sticky");
      @(negedge core_clk);
      check({31'h0, irq}, 32'h0, "irq cleared");
   endtask : sc_ds_single
   // repeating modes, second result count tells reset from no reset
   task automatic sc_ds_run(input logic [31:0] ctrl, input int second, input logic soc);
      axi_write(`OFF_CTRL, ctrl);
      if (soc) pulse(1'b0);
      else axi_write(`OFF_CTRL, ctrl | 32'h1);
      wait_high(ds_eoc, 300);
      check(snap, 4, "first after priming");
      expect_read(`OFF_DS_RESULT, 32'h5a5a3, "ds result");
      wait_high(ds_eoc, 300);
      check(snap, second, "next without trigger");
      axi_write(`OFF_CTRL, 32'h0);
      axi_read(`OFF_DS_RESULT);
      axi_read(`OFF_IRQ_STAT);
   endtask : sc_ds_run
   task automatic sc_sar();
      axi_write(`OFF_CTRL, 32'hc00);
      expect_read(`OFF_STATUS, 32'h0, "not ready while waking");
      repeat (1300) @(posedge core_clk);
      expect_read(`OFF_STATUS, 32'h4, "ready after wake");
      axi_write(`OFF_IRQ_MASK, 32'h2);
      t0 = ticks;
      pulse(1'b1);
      wait_high(sar_eof, 400);
      repeat (30) @(posedge core_clk);
      @(negedge core_clk);
      check({30'h0, sar_eof, irq}, 32'h3, "frame done held");
      expect_read(`OFF_SAR_RESULT, 32'ha5c, "binary search result");
      @(negedge core_clk);
      check({31'h0, sar_eof}, 32'h0, "read clears frame done");
      check(ticks - t0, 32'd18, "eighteen conversion clocks");
      repeat (300) @(negedge core_clk);
      check({31'h0, sar_eof}, 32'h0, "one per trigger");
      expect_read(`OFF_IRQ_STAT, 32'h2, "sar event sticky");
      axi_write(`OFF_CTRL, 32'ha00);
      wait_high(sar_eof, 400);
      expect_read(`OFF_SAR_RESULT, 32'ha5c, "continuous result");
      wait_high(sar_eof, 400);
      expect_read(`OFF_SAR_RESULT, 32'ha5c, "restarts alone");
      axi_write(`OFF_CTRL, 32'h0);
   endtask : sc_sar
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // conversion clock strobes seen so far
   always @(posedge core_clk) begin
      if (sar_clk_tick === 1'b1)
         ticks++;
   end
   // cut a hang short
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         print_verdict();
      end
   end
   initial begin
      {resetn, ds_soc, sar_sof, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      expect_read(`OFF_CTRL, 32'h100, "ctrl reset value");
      expect_read(`OFF_SAR_DIV, 32'h7, "divider reset value");
      axi_read(8'h1c);
      check({30'h0, rr}, 32'h3, "unmapped read refused");
      axi_write(8'h1c, 32'h0);
      check({30'h0, br}, 32'h3, "unmapped write refused");
      sc_ds_single();
      sc_ds_run(32'h10a, 4, 1'b1);
      sc_ds_run(32'h10e, 4, 1'b1);
      sc_ds_run(32'h14e, 5, 1'b1);
      sc_ds_run(32'h10c, 5, 1'b0);
      sc_sar();
      print_verdict();
   end
endmodule : tb
